// ==== rtl/wcac_params.svh ====
`ifndef WCAC_PARAMS_SVH
`define WCAC_PARAMS_SVH
// Register byte offsets (AXI4-Lite, one aligned word each)
`define WCAC_OFS_CTRL 12'h000
`define WCAC_OFS_HTH0 12'h004
`define WCAC_OFS_LTH0 12'h008
`define WCAC_OFS_HTH1 12'h00c
`define WCAC_OFS_LTH1 12'h010
`define WCAC_OFS_HITCNT 12'h014
`define WCAC_OFS_STATUS 12'h018
`define WCAC_OFS_LOWFLG 12'h01c
`define WCAC_OFS_HIGHFLG 12'h020
`define WCAC_OFS_BUFRD 12'h040
// Control field positions
`define WCAC_CTRL_START 0
`define WCAC_CTRL_POST 1
// Hit count field sits in bits 7:4
`define WCAC_HITCNT_LSB 4
// Reset values
`define WCAC_RST_HTH 12'hfff
`define WCAC_RST_LTH 12'h000
// Buffer depth
`define WCAC_BUF_DEPTH 16
// AXI responses
`define WCAC_RESP_OKAY 2'b00
`define WCAC_RESP_SLVERR 2'b10
`endif

// ==== rtl/wcac_pkg.sv ====
package wcac_pkg;
  // Capture states, Gray along idle -> filling -> done
  typedef enum logic [1:0] {
    WCAC_IDLE = 2'b00,
    WCAC_FILL = 2'b01,
    WCAC_DONE = 2'b11
  } wcac_state_e;
  // One converted result from the converter
  typedef struct packed {
    logic valid;
    logic chan;
    logic [11:0] code;
  } wcac_sample_s;
endpackage : wcac_pkg

// ==== rtl/wcac_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "wcac_params.svh"
// Notes on behaviour
// - High hit when result at or above high
// - Low hit when result at or below low
// - Low threshold zero hits only on zero
// - Alert when any qualified comparator fires while capture is armed
// - Alert waits for consecutive hit count
// - Sixteen-entry sample buffer readable by host
// - Pre mode: write buffer continuously until trigger
// - Pre mode: stop at triggering sample
// - Post mode: store nothing before trigger
// - Post mode: trigger plus fifteen, then stop
// - Needed hits equal count field plus one
// - Record first triggering channel as code
// - Latched flags, host clears with ones
module wcac_top (
  input wire logic clk, // 125 MHz clock
  input wire logic reset_n, // Async reset, active low
  input wire wcac_pkg::wcac_sample_s sampleIn, // Conversion result, same clock
  output logic alert_q, // Alert toward host
  output logic busy_q, // Capture under way
  input wire logic [11:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [11:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);
  import wcac_pkg::*;

  localparam int DEPTH = `WCAC_BUF_DEPTH; // Buffer entries

  // Overview of the datapath:
  // One converted result arrives per valid pulse, tagged with its channel.
  // Both comparators of that channel look at it in the same cycle.
  // Per-channel counters demand count field plus one consecutive hits before any alert,
  // so with a nonzero count a single noisy conversion cannot wake the host.
  // The first qualified hit after a start raises the alert and records the channel.
  // The capture buffer either runs before that point or starts at it.
  // Flags latch regardless of the capture state, so the host always sees history.

  // Configuration registers
  logic postMode_q; // 1 = capture after trigger
  logic [11:0] highThr_q [2]; // High thresholds per channel
  logic [11:0] lowThr_q [2]; // Low thresholds per channel
  logic [3:0] consecutiveHitCount_q; // Needed hits minus one
  // Status
  logic [1:0] lowFlag_q; // low_flag_chan1..0
  logic [1:0] highFlag_q; // high_flag_chan1..0
  logic [3:0] firstTriggerChannel_q; // Channel that first alerted
  wcac_state_e state_q; // Capture state
  logic [3:0] hiCnt_q [2]; // Consecutive high hits per channel
  logic [3:0] loCnt_q [2]; // Consecutive low hits per channel
  logic [11:0] buf_q [DEPTH]; // Sample storage
  logic [3:0] wrPtr_q; // Next write slot
  logic [3:0] postLeft_q; // Samples still to store after trigger

  // Comparator notes:
  // The channel bit selects the threshold pair, so both channels share one compare.
  // Sharing is safe because only one result arrives in any cycle.
  // Thresholds may be rewritten while armed; the next result uses the new value.
  // A high threshold of all ones still hits on a full-scale result.
  // Comparators on the incoming sample
  wire logic ch = sampleIn.chan; // Channel of this sample
  wire logic hiHit = sampleIn.code >= highThr_q[ch];
  // Less-or-equal gives exact-zero behaviour when low is zero
  wire logic loHit = sampleIn.code <= lowThr_q[ch];
  // A hit is qualified once the counter has already seen count hits
  wire logic hiQual = hiHit && (hiCnt_q[ch] == consecutiveHitCount_q);
  wire logic loQual = loHit && (loCnt_q[ch] == consecutiveHitCount_q);
  wire logic trigger = sampleIn.valid && (hiQual || loQual) && (state_q == WCAC_FILL) && !alert_q;
  wire logic filling = state_q == WCAC_FILL; // Capture armed

  // Capture notes:
  // Pre mode writes every valid result while armed and stops on the trigger.
  // Post mode ignores results until the trigger, then keeps sixteen in total.
  // The trigger itself is always written, in both modes.
  // Nothing is written once the state has left filling.
  // Buffer write decision
  wire logic preWrite = filling && !postMode_q && sampleIn.valid;
  wire logic postWrite = filling && postMode_q && sampleIn.valid && (alert_q || trigger);
  wire logic bufWrite = preWrite || postWrite;
  wire logic postLast = postWrite && alert_q && (postLeft_q == 4'h1);
  wire logic stopNow = (!postMode_q && trigger) || postLast;

  // Bus notes:
  // Address and data must both be offered before a write is taken.
  // This keeps the slave small at the cost of a cycle when a master staggers them.
  // Only one write and one read may be outstanding at any time.
  // Threshold writes need the two low byte lanes, so a partial write cannot
  // leave a threshold half updated.
  // AXI decode
  wire logic wrGo = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid; // Both channels present
  wire logic rdGo = s_axi_arvalid && !s_axi_rvalid; // Read request accepted
  wire logic wrLane0 = s_axi_wstrb[0]; // Low byte lane written
  wire logic wrLane1 = s_axi_wstrb[1]; // Second byte lane written
  wire logic startWr = wrGo && s_axi_awaddr == `WCAC_OFS_CTRL && wrLane0 && s_axi_wdata[`WCAC_CTRL_START];
  wire logic [1:0] lowClr = (wrGo && s_axi_awaddr == `WCAC_OFS_LOWFLG && wrLane0) ? s_axi_wdata[1:0] : 2'b00;
  wire logic [1:0] highClr = (wrGo && s_axi_awaddr == `WCAC_OFS_HIGHFLG && wrLane0) ? s_axi_wdata[1:0] : 2'b00;
  wire logic isBufAddr = s_axi_araddr >= `WCAC_OFS_BUFRD && s_axi_araddr < (`WCAC_OFS_BUFRD + 12'h040);
  wire logic [3:0] bufIdx = s_axi_araddr[5:2]; // Oldest-first index
  // Pre mode stops with the pointer just past the trigger, so that slot is the oldest
  wire logic [3:0] bufSlot = postMode_q ? bufIdx : bufIdx + wrPtr_q;
  wire logic wrKnown = s_axi_awaddr == `WCAC_OFS_CTRL || s_axi_awaddr == `WCAC_OFS_HTH0 ||
    s_axi_awaddr == `WCAC_OFS_LTH0 || s_axi_awaddr == `WCAC_OFS_HTH1 || s_axi_awaddr == `WCAC_OFS_LTH1 ||
    s_axi_awaddr == `WCAC_OFS_HITCNT || s_axi_awaddr == `WCAC_OFS_LOWFLG || s_axi_awaddr == `WCAC_OFS_HIGHFLG;
  logic [31:0] rdMux; // Read data selection
  logic rdKnown; // Address is mapped

  // Read notes:
  // Unmapped reads return zero data with an error response.
  // The control start bit always reads back as zero; it acts only on write.
  // Buffer words come back oldest first whatever the mode.
  // Read multiplexer
  always_comb begin
    rdMux = 32'h0000_0000;
    rdKnown = 1'b1;
    case (s_axi_araddr)
      `WCAC_OFS_CTRL: rdMux = {30'h0, postMode_q, 1'b0};
      `WCAC_OFS_HTH0: rdMux = {20'h0, highThr_q[0]};
      `WCAC_OFS_LTH0: rdMux = {20'h0, lowThr_q[0]};
      `WCAC_OFS_HTH1: rdMux = {20'h0, highThr_q[1]};
      `WCAC_OFS_LTH1: rdMux = {20'h0, lowThr_q[1]};
      `WCAC_OFS_HITCNT: rdMux = {24'h0, consecutiveHitCount_q, 4'h0};
      `WCAC_OFS_STATUS: rdMux = {24'h0, firstTriggerChannel_q, 1'b0, alert_q, state_q};
      `WCAC_OFS_LOWFLG: rdMux = {30'h0, lowFlag_q};
      `WCAC_OFS_HIGHFLG: rdMux = {30'h0, highFlag_q};
      default: begin
        rdMux = isBufAddr ? {20'h0, buf_q[bufSlot]} : 32'h0000_0000;
        rdKnown = isBufAddr;
      end
    endcase
  end

  // Write channel timing:
  // The ready pulses and the response appear one cycle after the take edge.
  // The response stands until the master accepts it.
  // A new write cannot be taken while a response is still waiting.
  // AXI write channel: address and data taken together, response next cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `WCAC_RESP_OKAY;
    end else begin
      s_axi_awready <= wrGo && !s_axi_awready;
      s_axi_wready <= wrGo && !s_axi_awready;
      if (wrGo && !s_axi_awready) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrKnown ? `WCAC_RESP_OKAY : `WCAC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel timing:
  // The address ready and the read answer rise together one cycle after the take.
  // Read data is registered, so it cannot change while the answer waits.
  // AXI read channel
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `WCAC_RESP_OKAY;
    end else begin
      s_axi_arready <= rdGo && !s_axi_arready;
      if (rdGo && !s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rdKnown ? `WCAC_RESP_OKAY : `WCAC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Configuration notes:
  // Writes land only in the single cycle in which the bus takes the write.
  // A write to an unknown offset changes nothing and is answered with an error.
  // Configuration registers; writes gated by the accept cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      postMode_q <= 1'b0;
      consecutiveHitCount_q <= 4'h0;
      highThr_q[0] <= `WCAC_RST_HTH;
      highThr_q[1] <= `WCAC_RST_HTH;
      lowThr_q[0] <= `WCAC_RST_LTH;
      lowThr_q[1] <= `WCAC_RST_LTH;
    end else if (wrGo && !s_axi_awready) begin
      case (s_axi_awaddr)
        `WCAC_OFS_CTRL: if (wrLane0) postMode_q <= s_axi_wdata[`WCAC_CTRL_POST];
        `WCAC_OFS_HTH0: if (wrLane0 && wrLane1) highThr_q[0] <= s_axi_wdata[11:0];
        `WCAC_OFS_LTH0: if (wrLane0 && wrLane1) lowThr_q[0] <= s_axi_wdata[11:0];
        `WCAC_OFS_HTH1: if (wrLane0 && wrLane1) highThr_q[1] <= s_axi_wdata[11:0];
        `WCAC_OFS_LTH1: if (wrLane0 && wrLane1) lowThr_q[1] <= s_axi_wdata[11:0];
        `WCAC_OFS_HITCNT: if (wrLane0) consecutiveHitCount_q <= s_axi_wdata[7:`WCAC_HITCNT_LSB];
        default: ;
      endcase
    end
  end

  // Counter notes:
  // Each channel has its own pair, so interleaved channels do not disturb each other.
  // Saturating keeps a long run of hits qualified instead of wrapping.
  // Start clears all counters so old runs cannot trigger a new capture.
  // Consecutive-hit counters; a clear result restarts them, saturate at the target
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 2; i++) begin
        hiCnt_q[i] <= 4'h0;
        loCnt_q[i] <= 4'h0;
      end
    end else if (startWr) begin
      for (int i = 0; i < 2; i++) begin
        hiCnt_q[i] <= 4'h0;
        loCnt_q[i] <= 4'h0;
      end
    end else if (sampleIn.valid) begin
      hiCnt_q[ch] <= !hiHit ? 4'h0 : (hiQual ? hiCnt_q[ch] : hiCnt_q[ch] + 4'h1);
      loCnt_q[ch] <= !loHit ? 4'h0 : (loQual ? loCnt_q[ch] : loCnt_q[ch] + 4'h1);
    end
  end

  // Flag notes:
  // Flags are write-one-to-clear, one bit per channel.
  // Letting the set win means an event coinciding with a clear is never lost.
  // Alert flags: a set in the same cycle as a clear wins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lowFlag_q <= 2'b00;
      highFlag_q <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        lowFlag_q[i] <= (sampleIn.valid && loQual && ch == i[0]) || (lowFlag_q[i] && !lowClr[i]);
        highFlag_q[i] <= (sampleIn.valid && hiQual && ch == i[0]) || (highFlag_q[i] && !highClr[i]);
      end
    end
  end

  // State notes:
  // Only the first trigger after start raises the alert and records the channel.
  // The alert is cleared only by the next start, so the host cannot miss it.
  // Capture state, alert and first-trigger channel
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= WCAC_IDLE;
      alert_q <= 1'b0;
      busy_q <= 1'b0;
      firstTriggerChannel_q <= 4'h0;
      wrPtr_q <= 4'h0;
      postLeft_q <= 4'h0;
    end else if (startWr) begin
      // Start clears the record and re-arms capture
      state_q <= WCAC_FILL;
      alert_q <= 1'b0;
      busy_q <= 1'b1;
      firstTriggerChannel_q <= 4'h0;
      wrPtr_q <= 4'h0;
      postLeft_q <= 4'hf;
    end else begin
      if (trigger) begin
        alert_q <= 1'b1;
        firstTriggerChannel_q <= {3'b000, ch};
      end
      if (bufWrite) wrPtr_q <= wrPtr_q + 4'h1;
      if (postWrite && alert_q) postLeft_q <= postLeft_q - 4'h1;
      if (stopNow) begin
        state_q <= WCAC_DONE;
        busy_q <= 1'b0;
      end
    end
  end

  // Storage notes:
  // Data is meaningful only after a capture, so reset logic is saved here.
  // Sample storage, no reset needed on data
  always_ff @(posedge clk) begin
    if (bufWrite) buf_q[wrPtr_q] <= sampleIn.code;
  end

endmodule : wcac_top
`default_nettype wire

// ==== tb/wcac_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
// Port-level watch on alert, capture stop and bus answers
module wcac_assertions (
  input wire logic clk, // Clock
  input wire logic reset_n, // Reset, active low
  input wire wcac_pkg::wcac_sample_s sampleIn, // Results
  input wire logic alert_q, // Alert
  input wire logic busy_q, // Capture armed
  input wire logic s_axi_awvalid, // Write address valid
  input wire logic s_axi_awready, // Write address taken
  input wire logic s_axi_wvalid, // Write data valid
  input wire logic s_axi_wready, // Write data taken
  input wire logic s_axi_bvalid, // Write answer
  input wire logic s_axi_bready, // Answer accepted
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address taken
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic s_axi_rvalid, // Read answer
  input wire logic s_axi_rready // Answer accepted
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_alert_on_sample: assert property ($rose(alert_q) |-> $past(sampleIn.valid)) else $error("alert rose idle");
  a_alert_when_armed: assert property ($rose(alert_q) |-> $past(busy_q)) else $error("alert while unarmed");
  a_stop_on_sample: assert property ($fell(busy_q) |-> $past(sampleIn.valid)) else $error("stop without sample");
  // Only a start write may drop the alert, so hold it while no write is near
  a_alert_held: assert property (alert_q && !s_axi_awvalid && !$past(s_axi_awvalid) |=> alert_q)
    else $error("alert dropped");
  a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=>
    s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write not answered");
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid && s_axi_arready)
    else $error("read not answered");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer moved");
endmodule : wcac_assertions
bind wcac_top wcac_assertions chk (.*);
`default_nettype wire

// ==== tb/wcac_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// Host controller: bus master; readies raised late to exercise holding
module wcac_host_model (
  input wire logic clk, // Clock
  output logic [11:0] s_axi_awaddr, // Write address
  output logic s_axi_awvalid, // Write address valid
  input wire logic s_axi_awready, // Write address taken
  output logic [31:0] s_axi_wdata, // Write data
  output logic [3:0] s_axi_wstrb, // Byte strobes
  output logic s_axi_wvalid, // Write data valid
  input wire logic s_axi_wready, // Write data taken
  input wire logic s_axi_bvalid, // Write answer
  output logic s_axi_bready, // Answer accepted
  output logic [11:0] s_axi_araddr, // Read address
  output logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address taken
  input wire logic s_axi_rvalid, // Read answer
  output logic s_axi_rready // Answer accepted
);
  logic [1:0] got; // Readies seen before the edge
  logic [1:0] done; // Channels already taken
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
  end
  // Whole-word write; readies are looked at before the edge to avoid races
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    done = 2'b00;
    do begin
      @(negedge clk);
      got = {s_axi_awready, s_axi_wready};
      @(posedge clk);
      if (got[1]) s_axi_awvalid <= 1'b0;
      if (got[0]) s_axi_wvalid <= 1'b0;
      done = done | got;
    end while (done != 2'b11);
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clk);
      got = {1'b0, s_axi_bvalid};
      @(posedge clk);
    end while (!got[0]);
    s_axi_bready <= 1'b0;
  endtask : wr
  // Single read; rready follows the address phase
  task rd(input logic [11:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge clk);
      got = {1'b0, s_axi_arready};
      @(posedge clk);
    end while (!got[0]);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clk);
      got = {1'b0, s_axi_rvalid};
      @(posedge clk);
    end while (!got[0]);
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : wcac_host_model
`default_nettype wire

// ==== tb/test_window_compare_alert_capture.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "wcac_params.svh"
// Bench: host model owns the bus, this module feeds conversions
module test_window_compare_alert_capture;
  import wcac_pkg::*;
  logic clk; // 125 MHz clock
  logic reset_n; // Reset, active low
  wcac_sample_s sampleIn; // Converter results
  logic alert_q, busy_q; // Alert and armed
  logic [11:0] s_axi_awaddr, s_axi_araddr; // Addresses
  logic [31:0] s_axi_wdata, s_axi_rdata; // Data
  logic [3:0] s_axi_wstrb; // Strobes
  logic [1:0] s_axi_bresp, s_axi_rresp; // Responses
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int miscompares = 0, n_checks = 0, cycles = 0;
  int seed = 32'h287d93c3; // Fixed seed
  logic [33:0] expQ[$]; // Expected {rresp, rdata}
  logic [11:0] pc[22]; // Pre-mode sample codes
  wcac_top DUT (.*);
  wcac_host_model host (.*);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task chk(input string nm, input logic [33:0] e, input logic [33:0] a);
    n_checks++;
    if (a !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, a);
    end
  endtask : chk
  task results();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  // Note the expectation, then read; the watcher compares it
  task rx(input logic [11:0] a, input logic [33:0] e);
    expQ.push_back(e);
    host.rd(a);
  endtask : rx
  // One conversion: valid for a single cycle
  task send(input logic ch, input logic [11:0] c);
    @(posedge clk);
    sampleIn <= '{1'b1, ch, c};
    @(posedge clk);
    sampleIn.valid <= 1'b0;
  endtask : send
  // Read data is stable a half cycle before the handshake edge
  always @(negedge clk) if (s_axi_rvalid && s_axi_rready && expQ.size() > 0)
    chk("rdata", expQ.pop_front(), {s_axi_rresp, s_axi_rdata});
  // Hang guard, far beyond the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    sampleIn = '0;
    reset_n = 1'b0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    rx(`WCAC_OFS_HTH0, 34'hfff);
    rx(`WCAC_OFS_LTH1, 34'h0);
    rx(12'h030, {`WCAC_RESP_SLVERR, 32'h0});
    host.wr(`WCAC_OFS_STATUS, 32'h0);
    chk("bresp", 34'(`WCAC_RESP_SLVERR), 34'(s_axi_bresp));
    $display("reset test done");
    host.wr(`WCAC_OFS_HTH0, 32'h800);
    chk("bresp", 34'(`WCAC_RESP_OKAY), 34'(s_axi_bresp));
    host.wr(`WCAC_OFS_HITCNT, 32'h10);
    host.wr(`WCAC_OFS_CTRL, 32'h1);
    for (int i = 0; i < 18; i++) pc[i] = 12'($random(seed)) & 12'h7ff | 12'h1;
    pc[18] = 12'h900;
    pc[19] = 12'h123;
    pc[20] = 12'h800;
    pc[21] = 12'hfff;
    for (int i = 0; i < 22; i++) begin
      send(1'b0, pc[i]);
      #1;
      if (i == 18 || i == 20) chk("alert", 34'h0, 34'(alert_q));
    end
    chk("alert", 34'h1, 34'(alert_q));
    chk("busy", 34'h0, 34'(busy_q));
    rx(`WCAC_OFS_STATUS, 34'h7);
    rx(`WCAC_OFS_HIGHFLG, 34'h1);
    for (int k = 0; k < 16; k++) rx(`WCAC_OFS_BUFRD + 12'(4 * k), 34'(pc[6 + k]));
    host.wr(`WCAC_OFS_HIGHFLG, 32'h1);
    rx(`WCAC_OFS_HIGHFLG, 34'h0);
    $display("pre capture test done");
    host.wr(`WCAC_OFS_LTH1, 32'h100);
    host.wr(`WCAC_OFS_HITCNT, 32'h0);
    host.wr(`WCAC_OFS_CTRL, 32'h3);
    for (int i = 0; i < 5; i++) send(1'b1, 12'h200 + 12'(i));
    send(1'b1, 12'h0f0);
    for (int i = 0; i < 17; i++) send(1'b1, 12'h300 + 12'(i));
    rx(`WCAC_OFS_STATUS, 34'h17);
    rx(`WCAC_OFS_BUFRD, 34'h0f0);
    for (int k = 1; k < 16; k++) rx(`WCAC_OFS_BUFRD + 12'(4 * k), 34'h2ff + 34'(k));
    rx(`WCAC_OFS_LOWFLG, 34'h2);
    send(1'b0, 12'h001);
    rx(`WCAC_OFS_LOWFLG, 34'h2);
    send(1'b0, 12'h000);
    rx(`WCAC_OFS_LOWFLG, 34'h3);
    $display("post capture test done");
    results();
  end
endmodule : test_window_compare_alert_capture
`default_nettype wire
